/* File: rtl/odv_pkg.sv */
// Purpose: Shared constants and types for the output driver and oscillator power registers
// Assumes: 32-bit APB data, each register in the low byte of one aligned word
// Notes: Register offsets are word indices; byte address is four times the index
package odv_pkg;

	// Word indices of the mapped registers
	localparam logic [7:0] THIRD_DRV_IDX = 8'h19; // Third driver config
	localparam logic [7:0] FOURTH_DIV_IDX = 8'h1a; // Fourth divide ratio
	localparam logic [7:0] FOURTH_DRV_IDX = 8'h1b; // Fourth driver config
	localparam logic [7:0] OSC_PWR_IDX = 8'h1c; // Oscillator power config
	localparam logic [7:0] UPDATE_IDX = 8'h20; // Transfer update command
	localparam logic [7:0] STATUS_IDX = 8'h21; // Live status readback

	// Reset values
	localparam logic [7:0] DRV_RESET = 8'h24; // Swing 10b, regulator on
	localparam logic [7:0] DIV_RESET = 8'h01; // Divide by one
	localparam logic [7:0] OSC_RESET = 8'h01; // High power, no skip
	localparam logic [7:0] DIV_OFF = 8'h00; // Ratio that disables the divider

	// Driver config field positions
	localparam int DRV_SWING_HI = 5; // Swing select msb
	localparam int DRV_SWING_LO = 4; // Swing select lsb
	localparam int DRV_TERM_BIT = 3; // Termination on
	localparam int DRV_REG_BIT = 2; // Regulator on
	localparam int DRV_DRIVE_BIT = 1; // Output enable
	localparam int DRV_CLEAR_BIT = 0; // Live divider clear

	// Oscillator power field positions
	localparam int OSC_SKIP_BIT = 1; // Settle wait skip
	localparam int OSC_MODE_BIT = 0; // Power mode

	// Command and status field positions
	localparam int UPDATE_BIT = 0; // Apply shadow copies
	localparam int STAT_READY_BIT = 0; // Oscillator settled
	localparam int STAT_DIV_EN_BIT = 1; // Fourth divider running
	localparam int STAT_PEND_BIT = 2; // Shadow differs from active

	// Settle wait timing
	localparam int unsigned SETTLE_TIME_S = 2; // Start-up wait in seconds
	localparam int unsigned CLK_HZ = 100_000_000; // pclk rate
	localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_S * CLK_HZ; // Wait in cycles

	// Driver amplitude codes
	typedef enum logic [1:0] {
		SWING_0V8 = 2'b00,
		SWING_0V9 = 2'b01,
		SWING_1V0 = 2'b10,
		SWING_1V1 = 2'b11
	} odv_swing_t;

	// One output driver's applied settings
	typedef struct packed {
		odv_swing_t swing_select; // Amplitude trim
		logic termination_on; // On-chip termination
		logic regulator_on; // Driver regulator
		logic drive_on; // Output enable
	} odv_drv_cfg_t;

	// Oscillator power settings
	typedef struct packed {
		logic osc_settle_skip; // Skip start-up wait
		logic osc_power_mode; // 1 = high power
	} odv_osc_cfg_t;

endpackage

/* File: rtl/odv_settle_timer.sv */
// Purpose: Start-up settle wait for the oscillator regulator
// Assumes: Counting starts at reset release
// Notes: The skip input ends the wait at once
`timescale 1ns/100ps

module odv_settle_timer #(
	parameter int unsigned LIMIT = odv_pkg::SETTLE_CYCLES // Wait length in cycles
) (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, active low
	input wire logic skip, // Applied skip setting
	output logic done // Wait finished, level
);

	logic [31:0] cnt_ff; // Cycles waited so far
	logic done_ff; // Sticky finish flag
	logic [31:0] last_cnt; // Final count of the wait

	assign last_cnt = 32'(LIMIT - 1);
	assign done = done_ff;

	// Wait counter; once done it stays done until the next reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 32'h0000_0000;
			done_ff <= 1'b0;
		end else if (done_ff) begin
			cnt_ff <= cnt_ff;
		end else if (skip) begin
			done_ff <= 1'b1;
		end else if (cnt_ff == last_cnt) begin
			done_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 32'h0000_0001;
		end
	end

	// A wait that ends without skip must have run its full length
	chk_wait_full: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(done_ff) && !$past(skip)) |-> ($past(cnt_ff) == last_cnt))
		else $error("settle wait ended early");

endmodule

/* File: rtl/odv_regs.sv */
// Purpose: Output driver, fourth divider and oscillator power registers on APB
// Assumes: Zero wait-state APB slave; software issues the update command
// Notes: Buffered fields apply on update; divider clear bits act at once
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps

module odv_regs #(
	parameter int unsigned SETTLE_CYCLES = odv_pkg::SETTLE_CYCLES // Start-up wait
) (
	input wire logic pclk, // Bus clock, 100 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready, always high
	output logic pslverr, // APB error for unmapped address
	output odv_pkg::odv_drv_cfg_t third_cfg, // Applied third driver settings
	output odv_pkg::odv_drv_cfg_t fourth_cfg, // Applied fourth driver settings
	output logic third_div_clear, // Third divider clear pulse
	output logic fourth_div_clear, // Fourth divider clear pulse
	output logic [7:0] fourth_divide_ratio, // Applied fourth ratio
	output logic fourth_div_enable, // Fourth divider running
	output logic fourth_div_tick, // One pulse per divided period
	output logic osc_settle_skip, // Applied skip setting
	output logic osc_power_mode, // Applied power mode
	output logic osc_ready // Start-up wait finished
);

	// Word index decoding is shared by the write, read and error paths,
	// but only the write and error paths also require an aligned address
	// Word index of an address, the low two address bits dropped
	function automatic logic [7:0] word_index(input logic [7:0] addr);
		word_index = {2'b00, addr[7:2]};
	endfunction

	// True when the address names a mapped register
	function automatic logic addr_hit(input logic [7:0] addr);
		logic [7:0] idx;
		idx = word_index(addr);
		addr_hit = (addr[1:0] == 2'b00) &&
			((idx == odv_pkg::THIRD_DRV_IDX) || (idx == odv_pkg::FOURTH_DIV_IDX) ||
			(idx == odv_pkg::FOURTH_DRV_IDX) || (idx == odv_pkg::OSC_PWR_IDX) ||
			(idx == odv_pkg::UPDATE_IDX) || (idx == odv_pkg::STATUS_IDX));
	endfunction

	// Packs the stored driver fields into register layout, clear bit reads zero
	function automatic logic [7:0] drv_to_byte(input odv_pkg::odv_drv_cfg_t c);
		drv_to_byte = {2'b00, c, 1'b0};
	endfunction

	// Extracts driver fields from a written byte, reserved bits dropped
	function automatic odv_pkg::odv_drv_cfg_t byte_to_drv(input logic [7:0] b);
		odv_pkg::odv_drv_cfg_t c;
		c.swing_select = odv_pkg::odv_swing_t'(b[odv_pkg::DRV_SWING_HI:odv_pkg::DRV_SWING_LO]);
		c.termination_on = b[odv_pkg::DRV_TERM_BIT];
		c.regulator_on = b[odv_pkg::DRV_REG_BIT];
		c.drive_on = b[odv_pkg::DRV_DRIVE_BIT];
		byte_to_drv = c;
	endfunction

	// Bus phase decode
	logic setup_ph; // First cycle of a transfer
	logic access_ph; // Completing cycle of a transfer
	logic wr_en; // Low byte write takes effect
	logic [7:0] wr_idx; // Word index of the current address
	logic [7:0] wr_byte; // Low byte of write data

	// Shadow copies written by software
	odv_pkg::odv_drv_cfg_t third_shd_ff; // Third driver shadow
	odv_pkg::odv_drv_cfg_t fourth_shd_ff; // Fourth driver shadow
	logic [7:0] div_shd_ff; // Fourth ratio shadow
	odv_pkg::odv_osc_cfg_t osc_shd_ff; // Oscillator shadow

	// Active copies that steer the outputs
	odv_pkg::odv_drv_cfg_t third_act_ff; // Third driver active
	odv_pkg::odv_drv_cfg_t fourth_act_ff; // Fourth driver active
	logic [7:0] div_act_ff; // Fourth ratio active
	odv_pkg::odv_osc_cfg_t osc_act_ff; // Oscillator active

	// Live pulses and divider state
	logic update_hit; // Update command written
	logic third_clr_ff; // Third clear pulse
	logic fourth_clr_ff; // Fourth clear pulse
	logic [7:0] div_cnt_ff; // Fourth divider phase
	logic div_tick_ff; // Fourth divider output pulse
	logic pending; // Shadow not yet applied

	// Read path
	logic [31:0] rd_ff; // Read data caught in setup
	logic err_ff; // Error caught in setup
	logic [7:0] nxt_rd; // Selected read byte
	logic settled; // Start-up wait finished

	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign wr_idx = word_index(paddr);
	assign wr_byte = pwdata[7:0];
	// Only byte lane 0 holds register bits; other lanes are ignored
	assign wr_en = access_ph && pwrite && pstrb[0] && addr_hit(paddr);
	assign update_hit = wr_en && (wr_idx == odv_pkg::UPDATE_IDX) && wr_byte[odv_pkg::UPDATE_BIT];
	assign pending = (third_shd_ff != third_act_ff) || (fourth_shd_ff != fourth_act_ff) ||
		(div_shd_ff != div_act_ff) || (osc_shd_ff != osc_act_ff);

	// Reads return these copies, so software sees what it wrote
	// even before the update command has moved it to the outputs
	// Shadow registers take software writes; reserved bits are not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			third_shd_ff <= odv_pkg::odv_drv_cfg_t'(odv_pkg::DRV_RESET[5:1]);
			fourth_shd_ff <= odv_pkg::odv_drv_cfg_t'(odv_pkg::DRV_RESET[5:1]);
			div_shd_ff <= odv_pkg::DIV_RESET;
			osc_shd_ff <= odv_pkg::odv_osc_cfg_t'(odv_pkg::OSC_RESET[1:0]);
		end else if (wr_en) begin
			case (wr_idx)
				odv_pkg::THIRD_DRV_IDX: begin
					third_shd_ff <= byte_to_drv(wr_byte);
				end
				odv_pkg::FOURTH_DRV_IDX: begin
					fourth_shd_ff <= byte_to_drv(wr_byte);
				end
				odv_pkg::FOURTH_DIV_IDX: begin
					div_shd_ff <= wr_byte;
				end
				odv_pkg::OSC_PWR_IDX: begin
					// Reserved bits 7:2 are dropped whatever the host sends
					osc_shd_ff <= odv_pkg::odv_osc_cfg_t'(wr_byte[1:0]);
				end
				default: begin
					// Update and status words keep nothing here
					osc_shd_ff <= osc_shd_ff;
				end
			endcase
		end
	end

	// All four copies move on one edge so the outputs never show
	// a half-applied mix of old and new settings
	// Active copies move only on the update command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			third_act_ff <= odv_pkg::odv_drv_cfg_t'(odv_pkg::DRV_RESET[5:1]);
			fourth_act_ff <= odv_pkg::odv_drv_cfg_t'(odv_pkg::DRV_RESET[5:1]);
			div_act_ff <= odv_pkg::DIV_RESET;
			osc_act_ff <= odv_pkg::odv_osc_cfg_t'(odv_pkg::OSC_RESET[1:0]);
		end else if (update_hit) begin
			third_act_ff <= third_shd_ff;
			fourth_act_ff <= fourth_shd_ff;
			div_act_ff <= div_shd_ff;
			osc_act_ff <= osc_shd_ff;
		end
	end

	// The clear bit is never stored, which is why it reads back as zero
	// and why a second clear needs a second write
	// Divider clear is live: a one-cycle pulse straight from the write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			third_clr_ff <= 1'b0;
			fourth_clr_ff <= 1'b0;
		end else begin
			third_clr_ff <= wr_en && (wr_idx == odv_pkg::THIRD_DRV_IDX) &&
				wr_byte[odv_pkg::DRV_CLEAR_BIT];
			fourth_clr_ff <= wr_en && (wr_idx == odv_pkg::FOURTH_DRV_IDX) &&
				wr_byte[odv_pkg::DRV_CLEAR_BIT];
		end
	end

	// Stand-in for the real channel divider, running on the bus clock
	// A new ratio takes effect from the running phase, with no restart
	// Fourth channel divider: one tick every ratio cycles, none at ratio zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_ff <= 8'h00;
			div_tick_ff <= 1'b0;
		end else if (fourth_clr_ff || (div_act_ff == odv_pkg::DIV_OFF)) begin
			// Clear restarts the phase; ratio zero parks the divider
			div_cnt_ff <= 8'h00;
			div_tick_ff <= 1'b0;
		end else if (div_cnt_ff >= div_act_ff - 8'h01) begin
			// Also catches a ratio lowered below the running phase
			div_cnt_ff <= 8'h00;
			div_tick_ff <= 1'b1;
		end else begin
			div_cnt_ff <= div_cnt_ff + 8'h01;
			div_tick_ff <= 1'b0;
		end
	end

	// Skip follows the applied copy, so writing the skip bit alone
	// does not shorten a wait that is already running
	// Oscillator regulator start-up wait
	odv_settle_timer #(
		.LIMIT(SETTLE_CYCLES)
	) u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.skip(osc_act_ff.osc_settle_skip),
		.done(settled)
	);

	// The update word has no storage and so falls to the default
	// Read byte selection; write-only bits read as zero
	always_comb begin
		nxt_rd = 8'h00;
		case (word_index(paddr))
			odv_pkg::THIRD_DRV_IDX: begin
				nxt_rd = drv_to_byte(third_shd_ff);
			end
			odv_pkg::FOURTH_DRV_IDX: begin
				nxt_rd = drv_to_byte(fourth_shd_ff);
			end
			odv_pkg::FOURTH_DIV_IDX: begin
				nxt_rd = div_shd_ff;
			end
			odv_pkg::OSC_PWR_IDX: begin
				nxt_rd = {6'b00_0000, osc_shd_ff};
			end
			odv_pkg::STATUS_IDX: begin
				nxt_rd[odv_pkg::STAT_READY_BIT] = settled;
				nxt_rd[odv_pkg::STAT_DIV_EN_BIT] = (div_act_ff != odv_pkg::DIV_OFF);
				nxt_rd[odv_pkg::STAT_PEND_BIT] = pending;
			end
			default: begin
				nxt_rd = 8'h00;
			end
		endcase
	end

	// Trade-off: a status bit that moves during the access phase
	// shows the value it had in the setup cycle
	// Read data and error are caught in setup so they come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ff <= 32'h0000_0000;
			err_ff <= 1'b0;
		end else if (setup_ph) begin
			rd_ff <= {24'h00_0000, nxt_rd};
			err_ff <= !addr_hit(paddr);
		end
	end

	// Limitation: no wait states, so every transfer takes exactly two cycles
	// Output drive; the slave never inserts wait states
	assign pready = 1'b1;
	assign pslverr = access_ph && err_ff;
	assign prdata = rd_ff;
	assign third_cfg = third_act_ff;
	assign fourth_cfg = fourth_act_ff;
	assign third_div_clear = third_clr_ff;
	assign fourth_div_clear = fourth_clr_ff;
	assign fourth_divide_ratio = div_act_ff;
	assign fourth_div_enable = (div_act_ff != odv_pkg::DIV_OFF);
	assign fourth_div_tick = div_tick_ff;
	assign osc_settle_skip = osc_act_ff.osc_settle_skip;
	assign osc_power_mode = osc_act_ff.osc_power_mode;
	assign osc_ready = settled;

	// Checks
	// All checks share the bus clock and drop out while reset is low
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_update_applies: assert property (
		update_hit |=> (third_cfg == $past(third_shd_ff)) && (fourth_divide_ratio == $past(div_shd_ff)))
		else $error("update did not apply shadow");

	chk_hold_active: assert property (
		!update_hit |=> $stable(third_cfg) && $stable(fourth_cfg) && $stable(osc_power_mode))
		else $error("active config moved without update");

	chk_clear_live: assert property (
		(wr_en && (wr_idx == odv_pkg::FOURTH_DRV_IDX) && wr_byte[0]) |=> fourth_div_clear)
		else $error("divider clear not live");

	chk_clear_self: assert property (
		third_div_clear |=> !third_div_clear)
		else $error("divider clear did not self clear");

	chk_clear_reads: assert property (
		(setup_ph && (word_index(paddr) == odv_pkg::THIRD_DRV_IDX)) |=> !prdata[0])
		else $error("clear bit read back as one");

	chk_div_off: assert property (
		(fourth_divide_ratio == odv_pkg::DIV_OFF) |=> !fourth_div_tick)
		else $error("disabled divider ticked");

	// Sampled reset keeps the release edge, when the tick was still held low, out
	chk_div_one: assert property (
		(presetn && (div_act_ff == odv_pkg::DIV_RESET) && !fourth_clr_ff) [*2] |->
		fourth_div_tick)
		else $error("divide by one missed a tick");

	chk_div_period: assert property (
		(div_tick_ff && (div_act_ff == 8'h03) && !update_hit && !fourth_clr_ff) ##1
		(!update_hit && !fourth_clr_ff) [*3] |-> !$past(div_tick_ff, 2) && div_tick_ff)
		else $error("divide by three period wrong");

	chk_skip_ready: assert property (
		osc_settle_skip |-> ##[0:2] osc_ready)
		else $error("skip did not end the wait");

	chk_write_swing: assert property (
		(wr_en && (wr_idx == odv_pkg::THIRD_DRV_IDX)) |=>
		(third_shd_ff.swing_select == $past(wr_byte[5:4])) && (third_shd_ff.drive_on == $past(wr_byte[1])))
		else $error("driver shadow not written");

	chk_write_fourth: assert property (
		(wr_en && (wr_idx == odv_pkg::FOURTH_DRV_IDX)) |=>
		(fourth_shd_ff.termination_on == $past(wr_byte[3])) &&
		(fourth_shd_ff.regulator_on == $past(wr_byte[2])))
		else $error("fourth driver shadow not written");

	chk_div_write: assert property (
		(wr_en && (wr_idx == odv_pkg::FOURTH_DIV_IDX)) |=> (div_shd_ff == $past(wr_byte)))
		else $error("ratio shadow not written");

	chk_osc_write: assert property (
		(wr_en && (wr_idx == odv_pkg::OSC_PWR_IDX)) |=> (osc_shd_ff == $past(wr_byte[1:0])))
		else $error("oscillator shadow not written");

	chk_update_rest: assert property (
		update_hit |=> (fourth_cfg == $past(fourth_shd_ff)) &&
		(osc_power_mode == $past(osc_shd_ff.osc_power_mode)))
		else $error("update missed a copy");

	chk_clear_restart: assert property (
		fourth_div_clear |=> !fourth_div_tick)
		else $error("divider clear did not restart the phase");

	chk_ready_sticky: assert property (
		osc_ready |=> osc_ready)
		else $error("start-up wait flag dropped");

endmodule

/* File: testbench/output_driver_osc_power_mode_regs_bench.sv */
// Purpose: Self-checking bench for the driver, divider and oscillator registers
// Assumes: Zero wait-state APB slave; settle count shortened by parameter
// Notes: An array model of the shadow and active copies predicts the register reads and the applied config outputs
`timescale 1ns/100ps

module output_driver_osc_power_mode_regs_bench;
	localparam int SET = 2000; // Short settle wait keeps the run brief
	logic pclk = 1'b0; // Bus clock
	logic presetn = 1'b0; // Reset, active low
	logic psel = 1'b0; // APB select
	logic penable = 1'b0; // APB access phase
	logic pwrite = 1'b0; // APB direction
	logic [7:0] paddr = 8'h00; // Byte address
	logic [31:0] pwdata = 32'h0000_0000; // Write data
	logic [3:0] pstrb = 4'hf; // Byte strobes
	logic [31:0] prdata; // Read data
	logic pready; // Ready
	logic pslverr; // Error response
	odv_pkg::odv_drv_cfg_t third_cfg; // Applied third settings
	odv_pkg::odv_drv_cfg_t fourth_cfg; // Applied fourth settings
	logic third_div_clear; // Third clear pulse
	logic fourth_div_clear; // Fourth clear pulse
	logic [7:0] fourth_divide_ratio; // Applied ratio
	logic fourth_div_enable; // Divider running
	logic fourth_div_tick; // Divided tick
	logic osc_settle_skip; // Applied skip
	logic osc_power_mode; // Applied power mode
	logic osc_ready; // Settle wait over
	int failures = 0; // Mismatches
	int checks = 0; // Comparisons
	int cyc = 0; // Cycle counter for the timeout
	logic [31:0] seed = 32'hf0c6_6418; // Xorshift state
	logic [7:0] shadow [4]; // Model of written copies
	logic [7:0] active [4]; // Model of applied copies
	logic [7:0] mask [4] = '{8'h3e, 8'hff, 8'h3e, 8'h03}; // Stored bits; clear bit is not kept
	logic [7:0] rl [5] = '{8'h01, 8'hff, 8'h00, 8'h03, 8'h00}; // Ratios, entry 2 random
	logic [31:0] rd; // Last read data
	logic er; // Last error flag

	odv_regs #(.SETTLE_CYCLES(SET)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .third_cfg(third_cfg),
		.fourth_cfg(fourth_cfg), .third_div_clear(third_div_clear),
		.fourth_div_clear(fourth_div_clear), .fourth_divide_ratio(fourth_divide_ratio),
		.fourth_div_enable(fourth_div_enable), .fourth_div_tick(fourth_div_tick),
		.osc_settle_skip(osc_settle_skip), .osc_power_mode(osc_power_mode),
		.osc_ready(osc_ready));

	// Free-running 100 MHz clock
	initial begin
		forever #5 pclk = ~pclk;
	end

	// Hang guard: far above the few thousand cycles the sequence needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// Xorshift source for field values
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Byte address of a word index
	function automatic logic [7:0] ba(input logic [7:0] idx);
		return {idx[5:0], 2'b00};
	endfunction

	// Expected status word from the model; pending when any shadow differs
	function automatic logic [31:0] stat_exp(input logic rdy);
		logic pend;
		pend = 1'b0;
		for (int i = 0; i < 4; i++) begin
			pend = pend | (shadow[i] != active[i]);
		end
		return {29'h0, pend, (active[1] != 8'h00), rdy};
	endfunction

	// Register read comparison
	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Port value comparison
	task automatic chk_out(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write and mirror into the model
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'b1, ba(idx), d, 4'hf);
		if (idx >= odv_pkg::THIRD_DRV_IDX && idx <= odv_pkg::OSC_PWR_IDX) begin
			shadow[idx - odv_pkg::THIRD_DRV_IDX] = d[7:0] & mask[idx - odv_pkg::THIRD_DRV_IDX];
		end
		if (idx == odv_pkg::UPDATE_IDX && d[0]) begin
			active = shadow; // Update copies every buffered field
		end
	endtask

	// Read a mapped register and compare with the shadow model
	task automatic rdchk(input logic [7:0] idx, input string nm);
		apb(1'b0, ba(idx), 32'h0000_0000, 4'hf);
		chk_reg(nm, {24'h0, shadow[idx - odv_pkg::THIRD_DRV_IDX]}, rd);
	endtask

	// Applied outputs against the active model
	task automatic chk_outs();
		chk_out("third_cfg", 32'(active[0][5:1]), 32'(third_cfg));
		chk_out("fourth_cfg", 32'(active[2][5:1]), 32'(fourth_cfg));
		chk_out("ratio", 32'(active[1]), 32'(fourth_divide_ratio));
		chk_out("div_enable", 32'(active[1] != 8'h00), 32'(fourth_div_enable));
		chk_out("power_mode", 32'(active[3][0]), 32'(osc_power_mode));
		chk_out("settle_skip", 32'(active[3][1]), 32'(osc_settle_skip));
	endtask

	// Reset held four cycles; model back to reset values
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		shadow = '{8'h24, 8'h01, 8'h24, 8'h01};
		active = shadow;
	endtask

	// Cycles between two ticks
	task automatic period(input logic [7:0] n);
		int k;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (fourth_div_tick !== 1'b1 && k < 700);
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (fourth_div_tick !== 1'b1 && k < 700);
		chk_out("tick_period", 32'(n), 32'(k));
	endtask

	// Counts, then the verdict
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		logic [31:0] r;
		logic [7:0] n;
		int k;
		do_reset();
		// Full settle wait with skip clear
		repeat (SET - 1) @(posedge pclk);
		chk_out("ready_early", 32'h0, 32'(osc_ready));
		repeat (2) @(posedge pclk);
		chk_out("ready_late", 32'h1, 32'(osc_ready));
		chk_outs();
		for (int i = 0; i < 4; i++) begin
			rdchk(odv_pkg::THIRD_DRV_IDX + 8'(i), "reset_value");
		end
		// Every swing code on both drivers; outputs wait for update
		for (int i = 0; i < 4; i++) begin
			r = xs();
			wr(odv_pkg::THIRD_DRV_IDX, {24'h0, 2'b00, 2'(i), r[3:1], 1'b0});
			wr(odv_pkg::FOURTH_DRV_IDX, {24'h0, 2'b00, 2'(3 - i), r[6:4], 1'b0});
			rdchk(odv_pkg::THIRD_DRV_IDX, "third_reg");
			rdchk(odv_pkg::FOURTH_DRV_IDX, "fourth_reg");
			chk_outs();
			wr(odv_pkg::UPDATE_IDX, 32'h0000_0001);
			@(posedge pclk);
			chk_outs();
		end
		// Write with byte 0 strobe low is dropped
		apb(1'b1, ba(odv_pkg::THIRD_DRV_IDX), 32'h0000_0030, 4'he);
		rdchk(odv_pkg::THIRD_DRV_IDX, "strobe_off");
		// Live divider clear on both drivers, no update
		for (int j = 0; j < 2; j++) begin
			wr(odv_pkg::THIRD_DRV_IDX + 8'(2 * j), {24'h0, shadow[2 * j][7:1], 1'b1});
			@(posedge pclk);
			chk_out("clear_pulse", 32'h1, 32'(j ? fourth_div_clear : third_div_clear));
			@(posedge pclk);
			chk_out("clear_end", 32'h0, 32'(j ? fourth_div_clear : third_div_clear));
			rdchk(odv_pkg::THIRD_DRV_IDX + 8'(2 * j), "clear_reads_zero");
		end
		// Ratios: one, maximum, random, three, off
		for (int j = 0; j < 5; j++) begin
			n = (j == 2) ? 8'(xs() % 200 + 3) : rl[j];
			wr(odv_pkg::FOURTH_DIV_IDX, {24'h0, n});
			rdchk(odv_pkg::FOURTH_DIV_IDX, "ratio_reg");
			wr(odv_pkg::UPDATE_IDX, 32'h0000_0001);
			@(posedge pclk);
			chk_outs();
			if (n != 8'h00) begin
				period(n);
			end else begin
				k = 0;
				repeat (300) begin
					@(posedge pclk);
					k += (fourth_div_tick !== 1'b0);
				end
				chk_out("idle_ticks", 32'h0, 32'(k));
			end
		end
		// Unmapped and unaligned places answer with an error
		apb(1'b0, 8'h88, 32'h0000_0000, 4'hf);
		chk_reg("unmapped_err", 32'h1, 32'(er));
		chk_reg("unmapped_data", 32'h0, rd);
		apb(1'b1, 8'h65, 32'h0000_0000, 4'hf);
		chk_reg("unaligned_err", 32'h1, 32'(er));
		// Low power mode, then skip after a second reset
		wr(odv_pkg::OSC_PWR_IDX, 32'h0000_0000);
		wr(odv_pkg::UPDATE_IDX, 32'h0000_0001);
		@(posedge pclk);
		chk_outs();
		do_reset();
		wr(odv_pkg::OSC_PWR_IDX, 32'h0000_0003);
		rdchk(odv_pkg::OSC_PWR_IDX, "osc_reg");
		apb(1'b0, ba(odv_pkg::STATUS_IDX), 32'h0000_0000, 4'hf);
		chk_reg("status_pending", stat_exp(1'b0), rd);
		wr(odv_pkg::UPDATE_IDX, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk_out("ready_skip", 32'h1, 32'(osc_ready));
		chk_outs();
		apb(1'b0, ba(odv_pkg::STATUS_IDX), 32'h0000_0000, 4'hf);
		chk_reg("status_ready", stat_exp(1'b1), rd);
		print_verdict();
	end
endmodule
